// ### rtl/tcs_dly.sv
`timescale 1ns/1ps
module tcs_dly #(
   parameter int W = 8
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_i, // Async reset
   input wire logic start_i, // Active link clock edge seen
   input wire logic [W-1:0] count_i, // Programmed delay in core cycles
   output logic fire_o // Sampling strobe
);

   logic [W-1:0] cnt_q;
   logic busy_q;
   logic fire_q;

   // Count down the programmed delay after each edge
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         fire_q <= 1'b0;
         if (start_i) begin
            cnt_q <= count_i;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == '0) begin
               fire_q <= 1'b1;
               busy_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end

   assign fire_o = fire_q;

endmodule

// ### rtl/tcs_pkg.sv
package tcs_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_TVAL = 8'h08;
   localparam logic [7:0] OFS_TCARE = 8'h0c;
   localparam logic [7:0] OFS_TDLY = 8'h10;
   localparam logic [7:0] OFS_SDLY = 8'h14;
   localparam logic [7:0] OFS_CDLY = 8'h18;
   localparam logic [7:0] OFS_STORED = 8'h1c;
   localparam logic [7:0] OFS_CHERR = 8'h20;
   localparam logic [7:0] OFS_ECNT = 8'h24;
   localparam logic [7:0] OFS_ISR = 8'h28;
   localparam logic [7:0] OFS_IMR = 8'h2c;
   localparam logic [7:0] OFS_MADR = 8'h30;
   localparam logic [7:0] OFS_CAPD = 8'h34;
   localparam logic [7:0] OFS_EXPD = 8'h38;
   localparam logic [7:0] OFS_ERRD = 8'h3c;

   // ****************************************
   // Control fields and modes
   // ****************************************
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SLOPE_BIT = 2;
   localparam int CTRL_RUN_BIT = 3;
   localparam int CTRL_ABORT_BIT = 4;
   localparam logic [1:0] MODE_START_ANA = 2'h0;
   localparam logic [1:0] MODE_STOP_ANA = 2'h1;
   localparam logic [1:0] MODE_START_CMP = 2'h2;
   localparam int COMPARE_TDLY = 1;

   // ****************************************
   // Interrupt bits
   // ****************************************
   localparam int IRQ_N = 3;
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_ERR = 2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARMED,
      ST_ACTIVE,
      ST_POST,
      ST_CMP
   } tcs_state_e;

endpackage

// ### rtl/tcs_sequencer.sv
// Operation
// - Start analysis triggers when all cared bits match; trigger word at address 0 with trigger delay zero.
// - Don't-care trigger positions never block nor cause a trigger.
// - Start analysis stays armed while any cared bit mismatches.
// - A matching word triggers again on the next acquisition.
// - Stop analysis captures continuously and stays active until a match.
// - Stop analysis ends on trigger; trigger word sits at the last position.
// - Start compare forces trigger delay one; trigger word at last address.
// - Start compare marks every channel that shows compare errors.
// - Each stored word is compared with expected data; mismatches are errors.
// - Larger trigger delay moves trigger word earlier; delay one gives last address.
// - Stored words equal stop delay plus one.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module tcs_sequencer import tcs_pkg::*; #(
   parameter int CH = 16,
   parameter int DEPTH = 1024,
   parameter int CDW = 8
) (
   input wire logic core_clk_i, // Core clock 200 MHz
   input wire logic rst_i, // Async reset, active high
   input wire logic link_clk_i, // Clock from device under test
   input wire logic [CH-1:0] chan_i, // Data channels from device under test
   input wire logic [7:0] reg_addr_i, // Register byte address
   input wire logic [31:0] reg_wdata_i, // Register write data
   input wire logic reg_we_i, // Write strobe
   input wire logic reg_re_i, // Read strobe
   output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
   output logic irq_o // Level interrupt
);

   localparam int AW = $clog2(DEPTH);

   // ****************************************
   // Declarations
   // ****************************************
   logic [CH:0] sync_w;
   logic [CH-1:0] word_w;
   logic lclk_prev_q;
   logic edge_w;
   logic smp_w;
   logic match_w;
   logic [1:0] mode_q;
   logic [1:0] run_mode_q;
   logic slope_q;
   logic [CH-1:0] tval_q;
   logic [CH-1:0] tcare_q;
   logic [AW-1:0] tdly_q;
   logic [AW-1:0] sdly_q;
   logic [CDW-1:0] cdly_q;
   logic [IRQ_N-1:0] imr_q;
   logic [IRQ_N-1:0] isr_q;
   logic [AW-1:0] madr_q;
   logic [31:0] rdata_q;
   logic irq_q;
   logic run_w;
   logic abort_w;
   tcs_state_e state_q;
   logic [AW-1:0] wp_q;
   logic [AW-1:0] trig_ptr_q;
   logic [AW-1:0] post_cnt_q;
   logic [AW:0] stored_q;
   logic [AW-1:0] eff_dly_w;
   logic [AW-1:0] base_w;
   logic [AW-1:0] rd_idx_w;
   logic [AW-1:0] cmp_idx_w;
   logic [AW-1:0] first_w;
   logic [AW-1:0] cmp_la_w;
   logic cap_en_w;
   logic trig_ev_q;
   logic done_ev_q;
   logic err_ev_q;
   logic [AW:0] cmp_a_q;
   logic cmp_v_q;
   logic cmp_end_w;
   logic [CH-1:0] cmp_cap_q;
   logic [CH-1:0] cmp_exp_q;
   logic [CH-1:0] diff_w;
   logic [CH-1:0] cherr_q;
   logic [AW:0] ecnt_q;
   logic [CH-1:0] cap_mem [DEPTH];
   logic [CH-1:0] exp_mem [DEPTH];

   // ****************************************
   // Link sampling
   // ****************************************

   // Synchronise link clock and channels together
   tcs_sync #(
      .W(CH + 1)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .d_i({link_clk_i, chan_i}),
      .q_o(sync_w)
   );

   assign word_w = sync_w[CH-1:0];

   // Previous link clock level for edge finding
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lclk_prev_q <= 1'b0;
      end else begin
         lclk_prev_q <= sync_w[CH];
      end
   end

   // Active edge chosen by slope
   assign edge_w = slope_q ? (lclk_prev_q & ~sync_w[CH]) : (~lclk_prev_q & sync_w[CH]);

   tcs_dly #(
      .W(CDW)
   ) u_dly (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(edge_w),
      .count_i(cdly_q),
      .fire_o(smp_w)
   );

   assign match_w = ~|((word_w ^ tval_q) & tcare_q);

   // ****************************************
   // Register bus
   // ****************************************
   // Run is taken only while idle, so a late run cannot clear pointers mid-capture
   assign run_w = reg_we_i & (reg_addr_i == OFS_CTRL) & reg_wdata_i[CTRL_RUN_BIT] & (state_q == ST_IDLE);
   assign abort_w = reg_we_i & (reg_addr_i == OFS_CTRL) & reg_wdata_i[CTRL_ABORT_BIT];

   // Configuration registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= MODE_START_ANA;
         slope_q <= 1'b0;
         tval_q <= '0;
         tcare_q <= '0;
         tdly_q <= '0;
         sdly_q <= '0;
         cdly_q <= '0;
         imr_q <= '0;
      end else if (reg_we_i) begin
         case (reg_addr_i)
            OFS_CTRL: begin
               mode_q <= reg_wdata_i[CTRL_MODE_LSB +: 2];
               slope_q <= reg_wdata_i[CTRL_SLOPE_BIT];
            end
            OFS_TVAL: tval_q <= reg_wdata_i[CH-1:0];
            OFS_TCARE: tcare_q <= reg_wdata_i[CH-1:0];
            OFS_TDLY: tdly_q <= reg_wdata_i[AW-1:0];
            OFS_SDLY: sdly_q <= reg_wdata_i[AW-1:0];
            OFS_CDLY: cdly_q <= reg_wdata_i[CDW-1:0];
            OFS_IMR: imr_q <= reg_wdata_i[IRQ_N-1:0];
            default: begin
            end
         endcase
      end
   end

   // Expected data loading and memory pointer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         madr_q <= '0;
      end else if (reg_we_i && reg_addr_i == OFS_MADR) begin
         madr_q <= reg_wdata_i[AW-1:0];
      end else if (reg_we_i && reg_addr_i == OFS_EXPD) begin
         madr_q <= madr_q + 1'b1;
      end else if (reg_re_i && (reg_addr_i == OFS_CAPD || reg_addr_i == OFS_ERRD)) begin
         madr_q <= madr_q + 1'b1;
      end
   end

   // Expected data memory write port
   always_ff @(posedge core_clk_i) begin
      if (reg_we_i && reg_addr_i == OFS_EXPD) begin
         exp_mem[madr_q] <= reg_wdata_i[CH-1:0];
      end
   end

   assign rd_idx_w = base_w + madr_q;

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else if (!reg_re_i) begin
         rdata_q <= '0;
      end else begin
         case (reg_addr_i)
            OFS_CTRL: rdata_q <= {27'h0, 1'b0, 1'b0, slope_q, mode_q};
            OFS_STAT: rdata_q <= 32'(state_q);
            OFS_TVAL: rdata_q <= 32'(tval_q);
            OFS_TCARE: rdata_q <= 32'(tcare_q);
            OFS_TDLY: rdata_q <= 32'(tdly_q);
            OFS_SDLY: rdata_q <= 32'(sdly_q);
            OFS_CDLY: rdata_q <= 32'(cdly_q);
            OFS_STORED: rdata_q <= 32'(stored_q);
            OFS_CHERR: rdata_q <= 32'(cherr_q);
            OFS_ECNT: rdata_q <= 32'(ecnt_q);
            OFS_ISR: rdata_q <= 32'(isr_q);
            OFS_IMR: rdata_q <= 32'(imr_q);
            OFS_MADR: rdata_q <= 32'(madr_q);
            OFS_CAPD: rdata_q <= 32'(cap_mem[rd_idx_w]);
            OFS_EXPD: rdata_q <= 32'(exp_mem[madr_q]);
            OFS_ERRD: rdata_q <= 32'(cap_mem[rd_idx_w] ^ exp_mem[madr_q]);
            default: rdata_q <= '0;
         endcase
      end
   end

   assign reg_rdata_o = rdata_q;

   // ****************************************
   // Acquisition sequencing
   // ****************************************

   assign eff_dly_w = (run_mode_q == MODE_START_CMP) ? AW'(COMPARE_TDLY) : tdly_q;

   // stop mode puts trigger word last
   // trigger delay moves the word earlier
   assign base_w = (run_mode_q == MODE_STOP_ANA) ? (trig_ptr_q + 1'b1 - stored_q[AW-1:0])
                                                  : (trig_ptr_q + eff_dly_w);

   assign cap_en_w = smp_w & (state_q == ST_ARMED || state_q == ST_ACTIVE || state_q == ST_POST);

   // Capture memory write port and pointer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_q <= '0;
      end else if (run_w) begin
         wp_q <= '0;
      end else if (cap_en_w) begin
         wp_q <= wp_q + 1'b1;
      end
   end

   // Captured words storage
   always_ff @(posedge core_clk_i) begin
      if (cap_en_w) begin
         cap_mem[wp_q] <= word_w;
      end
   end

   // Main sequencer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         run_mode_q <= MODE_START_ANA;
         trig_ptr_q <= '0;
         post_cnt_q <= '0;
         stored_q <= '0;
         trig_ev_q <= 1'b0;
         done_ev_q <= 1'b0;
      end else begin
         trig_ev_q <= 1'b0;
         done_ev_q <= 1'b0;
         if (abort_w) begin
            state_q <= ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (run_w) begin
                     run_mode_q <= reg_wdata_i[CTRL_MODE_LSB +: 2];
                     // stored count set by stop delay
                     stored_q <= (AW + 1)'(sdly_q) + 1'b1;
                     // stop mode starts capturing at once
                     if (reg_wdata_i[CTRL_MODE_LSB +: 2] == MODE_STOP_ANA) begin
                        state_q <= ST_ACTIVE;
                     end else begin
                        state_q <= ST_ARMED;
                     end
                  end
               end
               ST_ARMED: begin
                  if (smp_w && match_w) begin
                     trig_ptr_q <= wp_q;
                     trig_ev_q <= 1'b1;
                     post_cnt_q <= AW'(1);
                     if (sdly_q == '0) begin
                        state_q <= ST_CMP;
                     end else begin
                        state_q <= ST_POST;
                     end
                  end
               end
               ST_ACTIVE: begin
                  if (smp_w && match_w) begin
                     trig_ptr_q <= wp_q;
                     trig_ev_q <= 1'b1;
                     state_q <= ST_CMP;
                  end
               end
               ST_POST: begin
                  // end after stop delay plus one words
                  if (smp_w) begin
                     if (post_cnt_q == sdly_q) begin
                        state_q <= ST_CMP;
                     end else begin
                        post_cnt_q <= post_cnt_q + 1'b1;
                     end
                  end
               end
               ST_CMP: begin
                  if (cmp_end_w) begin
                     state_q <= ST_IDLE;
                     done_ev_q <= 1'b1;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // ****************************************
   // Expected data compare
   // ****************************************
   // sweep only the stored words
   assign first_w = (run_mode_q == MODE_STOP_ANA) ? base_w : trig_ptr_q;
   assign cmp_idx_w = first_w + cmp_a_q[AW-1:0];
   assign cmp_la_w = cmp_idx_w - base_w;
   assign cmp_end_w = (cmp_a_q == stored_q) & ~cmp_v_q;
   assign diff_w = cmp_cap_q ^ cmp_exp_q;

   // Sweep stored words against expected memory
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_a_q <= '0;
         cmp_v_q <= 1'b0;
         cmp_cap_q <= '0;
         cmp_exp_q <= '0;
      end else if (run_w) begin
         cmp_a_q <= '0;
         cmp_v_q <= 1'b0;
      end else begin
         cmp_v_q <= 1'b0;
         if (state_q == ST_CMP && cmp_a_q != stored_q) begin
            cmp_cap_q <= cap_mem[cmp_idx_w];
            cmp_exp_q <= exp_mem[cmp_la_w];
            cmp_v_q <= 1'b1;
            cmp_a_q <= cmp_a_q + 1'b1;
         end
      end
   end

   // Error counting and channel marking
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ecnt_q <= '0;
         cherr_q <= '0;
         err_ev_q <= 1'b0;
      end else if (run_w) begin
         ecnt_q <= '0;
         cherr_q <= '0;
         err_ev_q <= 1'b0;
      end else begin
         err_ev_q <= 1'b0;
         if (cmp_v_q && diff_w != '0) begin
            ecnt_q <= ecnt_q + 1'b1;
            err_ev_q <= 1'b1;
            if (run_mode_q == MODE_START_CMP) begin
               cherr_q <= cherr_q | diff_w;
            end
         end
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************

   // Sticky status, write one to clear, event wins
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         isr_q <= '0;
      end else begin
         if (reg_we_i && reg_addr_i == OFS_ISR) begin
            isr_q <= (isr_q & ~reg_wdata_i[IRQ_N-1:0]) | {err_ev_q, done_ev_q, trig_ev_q};
         end else begin
            isr_q <= isr_q | {err_ev_q, done_ev_q, trig_ev_q};
         end
      end
   end

   // Interrupt output flop
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(isr_q & imr_q);
      end
   end

   assign irq_o = irq_q;

endmodule

// ### rtl/tcs_sync.sv
`timescale 1ns/1ps
module tcs_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_i, // Async reset
   input wire logic [W-1:0] d_i, // Foreign-domain level
   output logic [W-1:0] q_o // Synchronised level
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Two flip-flop synchroniser
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule

// ### verification/tcs_dut_model.sv
`timescale 1ns/1ps
// ****************************************
// Circuit under test: link clock and data
// ****************************************
module tcs_dut_model (
   input wire logic ena_i, // Run the link clock
   output logic link_clk_o, // Link clock, low while stopped
   output logic [15:0] chan_o // Channel word
);
   logic [7:0] cnt;
   // Free phase against core clock; word advances on falling edge
   initial begin
      link_clk_o = 1'b0;
      cnt = 8'h00;
      #1.3;
      forever begin
         #40;
         if (!ena_i) begin
            link_clk_o = 1'b0;
            cnt = 8'h00;
         end else begin
            link_clk_o = ~link_clk_o;
            if (!link_clk_o) begin
               cnt = cnt + 8'h01;
            end
         end
      end
   end
   // Top bit marks the low half of the link period
   assign chan_o = {~link_clk_o, ~cnt[6:0], cnt};
endmodule

// ### verification/tcs_properties.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module tcs_props import tcs_pkg::*; #(
   parameter int CH = 16,
   parameter int DEPTH = 1024
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_i, // Async reset
   input wire logic link_clk_i, // Link clock
   input wire logic [CH-1:0] chan_i, // Channels
   input wire logic [7:0] reg_addr_i, // Address
   input wire logic [31:0] reg_wdata_i, // Write data
   input wire logic reg_we_i, // Write strobe
   input wire logic reg_re_i, // Read strobe
   input wire logic [31:0] reg_rdata_o, // Read data
   input wire logic irq_o // Interrupt
);
   logic [2:0] imr_q;
   logic ctrl_seen_q;
   logic link_seen_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Shadow of the interrupt mask
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         imr_q <= 3'h0;
      end else if (reg_we_i && reg_addr_i == OFS_IMR) begin
         imr_q <= reg_wdata_i[2:0];
      end
   end
   // History of control writes and link activity
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_seen_q <= 1'b0;
         link_seen_q <= 1'b0;
      end else begin
         ctrl_seen_q <= ctrl_seen_q | (reg_we_i && reg_addr_i == OFS_CTRL);
         link_seen_q <= link_seen_q | link_clk_i;
      end
   end
   rdata_quiet_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
      else $error("read data not zero outside answer");
   stat_range_a: assert property (reg_re_i && reg_addr_i == OFS_STAT |=> reg_rdata_o <= 32'h4)
      else $error("state code out of range");
   idle_stat_a: assert property (reg_re_i && reg_addr_i == OFS_STAT && !ctrl_seen_q |=> reg_rdata_o == 32'h0)
      else $error("state left idle without run");
   cap_width_a: assert property (reg_re_i && reg_addr_i == OFS_CAPD |=> reg_rdata_o[31:CH] == '0)
      else $error("capture word upper bits set");
   mark_width_a: assert property (reg_re_i && reg_addr_i == OFS_CHERR |=> reg_rdata_o[31:CH] == '0)
      else $error("channel marks upper bits set");
   stored_bound_a: assert property (reg_re_i && reg_addr_i == OFS_STORED |=> reg_rdata_o <= DEPTH)
      else $error("stored count above depth");
   no_sample_trig_a: assert property (reg_re_i && reg_addr_i == OFS_ISR && !link_seen_q
      |=> !reg_rdata_o[IRQ_TRIG])
      else $error("trigger flagged without link clock");
   irq_mask_a: assert property ((imr_q == 3'h0) [*2] |-> !irq_o)
      else $error("interrupt high while fully masked");
   cover property (reg_re_i && reg_addr_i == OFS_STAT ##1 reg_rdata_o == 32'h1);
   cover property (reg_re_i && reg_addr_i == OFS_STAT ##1 reg_rdata_o == 32'h2);
   cover property ($rose(irq_o));
endmodule
bind tcs_sequencer tcs_props #(.CH(CH), .DEPTH(DEPTH)) i_props (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .chan_i(chan_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
   .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

// ### verification/trigger_capture_sequencer_test.sv
`timescale 1ns/1ps
module trigger_capture_sequencer_test;
   import tcs_pkg::*;
   localparam int DEPTH = 1024;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ena = 1'b0;
   logic link_clk;
   logic [15:0] chan;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [31:0] rdata;
   logic irq;
   logic [31:0] v;
   logic [31:0] acc;
   logic [7:0] tt;
   int sdv;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;
   // ****************************************
   // Clock, parts and helpers
   // ****************************************
   always #2.5 core_clk_i = ~core_clk_i;
   tcs_dut_model i_model (.ena_i(ena), .link_clk_o(link_clk), .chan_o(chan));
   tcs_sequencer #(.CH(16), .DEPTH(DEPTH), .CDW(8)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .link_clk_i(link_clk), .chan_i(chan), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
      .reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq));
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc > 60000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge core_clk_i);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_i);
      addr <= a;
      re <= 1'b1;
      @(posedge core_clk_i);
      re <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk32(n, e, v);
   endtask
   // Channel word seen j samples after the trigger word
   function automatic logic [31:0] word(input int j, input logic ph);
      logic [7:0] k;
      k = tt + j[7:0];
      return {16'h0, ph, ~k[6:0], k};
   endfunction
   task automatic cap(input int a, input logic [31:0] e);
      wr(OFS_MADR, 32'(a % DEPTH));
      rchk("capture", OFS_CAPD, e);
   endtask
   // One acquisition with random trigger word and stop delay
   task automatic run(input logic [2:0] m, input int d, input int cd, input logic [31:0] st);
      int n;
      tt = 8'h10 + 8'($urandom % 64);
      sdv = 2 + int'($urandom % 6);
      wr(OFS_TVAL, {24'h0, tt});
      wr(OFS_TCARE, 32'h00ff);
      wr(OFS_TDLY, 32'(d));
      wr(OFS_SDLY, 32'(sdv));
      wr(OFS_CDLY, 32'(cd));
      wr(OFS_ISR, 32'h7);
      wr(OFS_CTRL, 32'h8 | {29'h0, m});
      ena <= 1'b1;
      repeat (48) @(posedge core_clk_i);
      rchk("state", OFS_STAT, st);
      n = 0;
      v = 32'h0;
      while (v[IRQ_DONE] !== 1'b1 && n < 3000) begin
         rd(OFS_ISR);
         n++;
      end
      chk32("isr", 32'h7, v);
      ena <= 1'b0;
      chk32("irq", 32'h1, {31'h0, irq});
      rchk("stored", OFS_STORED, 32'(sdv + 1));
      rchk("errors", OFS_ECNT, 32'(sdv + 1));
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      int d;
      void'($urandom(32'h1fc4e2ae));
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rchk("state", OFS_STAT, 32'h0);
      rchk("isr", OFS_ISR, 32'h0);
      rchk("unmapped", 8'hfc, 32'h0);
      wr(OFS_IMR, 32'h7);
      wr(OFS_MADR, 32'h0);
      repeat (DEPTH) wr(OFS_EXPD, 32'h0);
      run(MODE_START_ANA, 0, 0, 32'h1);
      cap(0, word(0, 1'b0));
      cap(1, word(1, 1'b0));
      wr(OFS_MADR, 32'h0);
      rchk("error data", OFS_ERRD, word(0, 1'b0));
      rchk("marks", OFS_CHERR, 32'h0);
      wr(OFS_IMR, 32'h0);
      repeat (2) @(posedge core_clk_i);
      chk32("irq", 32'h0, {31'h0, irq});
      wr(OFS_IMR, 32'h7);
      wr(OFS_ISR, 32'h7);
      repeat (2) @(posedge core_clk_i);
      chk32("irq", 32'h0, {31'h0, irq});
      d = 2 + int'($urandom % 30);
      run(MODE_START_ANA, d, 8, 32'h1);
      cap(DEPTH - d, word(0, 1'b1));
      // Stop analysis on the falling link edge: samples land in the low half
      run({1'b1, MODE_STOP_ANA}, 0, 0, 32'h2);
      cap(sdv, word(0, 1'b1));
      cap(sdv - 1, word(-1, 1'b1));
      run(MODE_START_CMP, 0, 0, 32'h1);
      cap(DEPTH - 1, word(0, 1'b0));
      cap(0, word(1, 1'b0));
      acc = 32'h0;
      for (int j = 0; j <= sdv; j++) begin
         acc = acc | word(j, 1'b0);
      end
      rchk("marks", OFS_CHERR, acc);
      // Arm with no link clock, refuse a second run, then abort
      wr(OFS_CTRL, 32'h8);
      rchk("state", OFS_STAT, 32'h1);
      wr(OFS_CTRL, 32'h9);
      rchk("state", OFS_STAT, 32'h1);
      wr(OFS_CTRL, 32'h10);
      rchk("state", OFS_STAT, 32'h0);
      end_sim();
   end
endmodule
